// *** hdl/sensor_frontend_pkg.sv ***
// Shared constants and types for the per-axis position sensor front end
package sensor_frontend_pkg;
  localparam int AXES = 4;
  localparam int CLK_HZ = 20_000_000;
  // Register byte offsets
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_ACTIVE = 8'h04;
  localparam logic [7:0] OFS_DIR = 8'h08;
  localparam logic [7:0] OFS_SIGTYPE = 8'h0c;
  localparam logic [7:0] OFS_INDEXUSE = 8'h10;
  localparam logic [7:0] OFS_FAULTUSE = 8'h14;
  localparam logic [7:0] OFS_INDEXLIVE = 8'h18;
  localparam logic [7:0] OFS_INDEXLATCH = 8'h1c;
  localparam logic [7:0] OFS_FAULTLIVE = 8'h20;
  localparam logic [7:0] OFS_ERROR = 8'h24;
  localparam logic [7:0] OFS_CONTROL = 8'h28;
  localparam logic [7:0] OFS_PERIOD0 = 8'h40;
  localparam logic [7:0] OFS_VEL0 = 8'h50;
  localparam logic [7:0] OFS_AMP0 = 8'h60;
  localparam logic [7:0] OFS_COUNT0 = 8'h70;
  // Period in nanometres: 0.000002 mm = 2 nm, 4.0 mm = 4000000 nm
  localparam logic [31:0] PERIOD_MIN = 32'h0000_0002;
  localparam logic [31:0] PERIOD_MAX = 32'h003d_0900;
  localparam logic [31:0] PERIOD_RST = 32'h0000_4e20;
  // Velocity in um/s: 0.01 mm/s = 10, 20.0 mm/s = 20000
  localparam logic [31:0] VEL_MIN = 32'h0000_000a;
  localparam logic [31:0] VEL_MAX = 32'h0000_4e20;
  localparam logic [31:0] VEL_RST = 32'h0000_01f4;
  // Amplitude percent scale and validity threshold
  localparam logic [7:0] AMP_FULL = 8'h64;
  localparam logic [7:0] AMP_LOW_RST = 8'h14;
  localparam logic [1:0] AXIS_ALL = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int SYNC_STAGES = 3;
  typedef struct packed {
    logic quad_a;
    logic quad_b;
    logic index_mark;
    logic sensor_fault_input;
  } sensor_pins_type;
  typedef struct packed {
    logic homing_done;
    logic powerup_auto;
  } activate_type;
endpackage

// *** hdl/pin_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // First stage only feeds the second
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Change counts once stages two and three agree
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      level <= 1'b0;
    end else if (s2_q == s3_q) begin
      level <= s3_q;
    end
  end
endmodule
`default_nettype wire

// *** hdl/quad_counter.sv ***
// Quadrature edge counter, four counts per signal period
`timescale 1ns/1ps
`default_nettype none
module quad_counter (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic reverse,
  input wire logic clear,
  output logic [31:0] count
);
  logic [1:0] prev_q;
  logic [1:0] cur;
  logic up;
  logic step;
  assign cur = {quad_a, quad_b};
  // Gray transition: step on any single-bit change
  always_comb begin
    step = ^(cur ^ prev_q) ;
    up = prev_q[1] ^ cur[0];
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_q <= 2'b00;
    end else begin
      prev_q <= cur;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= 32'h0000_0000;
    end else if (clear) begin
      count <= 32'h0000_0000;
    end else if (step) begin
      if (up ^ reverse) begin
        count <= count + 32'h0000_0001;
      end else begin
        count <= count - 32'h0000_0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/axis_position_sensor_frontend.sv ***
// Four-axis position sensor front end with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - enable mask gates sensor activation
// - activate after homing or auto power-up
// - report active flag per axis
// - store period, 0.000002 to 4.0 mm
// - direction bit reverses count
// - direction fixed by device in closed loop
// - store velocity, 0.01 to 20.0 mm/s
// - analog or quadrature; digital-in-analog invalid
// - index use zeroes position at homing
// - fault-use bit routes fault to error
// - low fault input means sensor error
// - report live index state
// - latched index flag cleared by read
// - report live fault state
// - fault or low amplitude sets error
// - writing zero clears error state
// - readable signal amplitude per axis
// - settings held per axis, except one shared low-amplitude threshold
// - amplitude 100 means full undistorted
// - edge counter, four per period
module axis_position_sensor_frontend
  import sensor_frontend_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire sensor_frontend_pkg::sensor_pins_type pins [4],
  input wire logic [7:0] amp_raw [4],
  input wire sensor_frontend_pkg::activate_type activate [4],
  input wire logic at_lower_limit [4],
  output logic [3:0] closed_loop_en,
  output logic [3:0] zero_request,
  output logic error_state,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sensor_frontend_pkg::*;

  logic [3:0] enable_q;
  logic [3:0] active_q;
  logic [3:0] dir_q;
  logic [3:0] sigtype_q;
  logic [3:0] indexuse_q;
  logic [3:0] faultuse_q;
  logic [3:0] index_latch_q;
  logic [3:0] error_q;
  logic [7:0] amp_low_q;
  logic [31:0] period_q [4];
  logic [31:0] vel_q [4];
  logic [7:0] amp_q [4];
  logic [3:0] index_live;
  logic [3:0] fault_pin;
  logic [3:0] quad_a_s;
  logic [3:0] quad_b_s;
  logic [3:0] fault_live;
  logic [3:0] invalid;
  logic [3:0] count_clear;
  logic [3:0] seek_index_q;
  logic [31:0] count [4];

  // AXI write and read channel state
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] rd_addr;
  logic [31:0] rd_value;
  logic rd_ok;

  // Byte-enable merge, used for period and velocity writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Clamp a value into an allowed range
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // Per-axis input synchronisers and counters
  generate
    for (genvar i = 0; i < AXES; i++) begin : g_axis
      pin_sync u_idx (
        .core_clk(core_clk),
        .reset(reset),
        .pin(pins[i].index_mark),
        .level(index_live[i])
      );
      pin_sync u_flt (
        .core_clk(core_clk),
        .reset(reset),
        // Inverted ahead of the sync so reset reads as no fault
        .pin(~pins[i].sensor_fault_input),
        .level(fault_pin[i])
      );
      pin_sync u_qa (
        .core_clk(core_clk),
        .reset(reset),
        .pin(pins[i].quad_a),
        .level(quad_a_s[i])
      );
      pin_sync u_qb (
        .core_clk(core_clk),
        .reset(reset),
        .pin(pins[i].quad_b),
        .level(quad_b_s[i])
      );
      quad_counter u_cnt (
        .core_clk(core_clk),
        .reset(reset),
        .quad_a(quad_a_s[i]),
        .quad_b(quad_b_s[i]),
        .reverse(dir_q[i]),
        .clear(count_clear[i]),
        .count(count[i])
      );
      // low level on fault pin is an error
      assign fault_live[i] = fault_pin[i];
      // a digital sensor in analog mode reads low amplitude
      // fault or low amplitude makes the sensor invalid
      assign invalid[i] = active_q[i] &
        ((~sigtype_q[i] & (amp_q[i] < amp_low_q)) |
         (faultuse_q[i] & fault_live[i]));
      // zero position on index mark during homing
      assign count_clear[i] = seek_index_q[i] & index_live[i];
    end
  endgenerate

  // saturate so 100 is full undistorted scale
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < AXES; i++) begin
        amp_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < AXES; i++) begin
        amp_q[i] <= (amp_raw[i] > AMP_FULL) ? AMP_FULL : amp_raw[i];
      end
    end
  end

  // after lower limit, seek index when use bit set
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      seek_index_q <= 4'h0;
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (count_clear[i] | ~indexuse_q[i]) begin
          seek_index_q[i] <= 1'b0;
        end else if (at_lower_limit[i]) begin
          seek_index_q[i] <= 1'b1;
        end
      end
    end
  end

  // Write address and data taken in either order
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (waddr_q[1:0] == 2'b00 && waddr_q < 8'h80) ?
                       RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Bit-mask configuration registers and amplitude threshold
  // direction writes refused while closed loop runs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      enable_q <= 4'h0;
      dir_q <= 4'h0;
      sigtype_q <= 4'h0;
      indexuse_q <= 4'h0;
      faultuse_q <= 4'h0;
      amp_low_q <= AMP_LOW_RST;
    end else if (wr_fire) begin
      unique case (waddr_q)
        OFS_ENABLE: enable_q <= wdata_q[3:0];
        OFS_DIR: dir_q <= (dir_q & closed_loop_en) |
                          (wdata_q[3:0] & ~closed_loop_en);
        OFS_SIGTYPE: sigtype_q <= wdata_q[3:0];
        OFS_INDEXUSE: indexuse_q <= wdata_q[3:0];
        OFS_FAULTUSE: faultuse_q <= wdata_q[3:0];
        OFS_CONTROL: amp_low_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // period stored per axis, clamped to range
  // velocity stored per axis, clamped to range
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < AXES; i++) begin
        period_q[i] <= PERIOD_RST;
        vel_q[i] <= VEL_RST;
      end
    end else if (wr_fire) begin
      for (int i = 0; i < AXES; i++) begin
        if (waddr_q == OFS_PERIOD0 + 8'(4 * i)) begin
          period_q[i] <= clamp(merge(period_q[i], wdata_q, wstrb_q),
                               PERIOD_MIN, PERIOD_MAX);
        end
        if (waddr_q == OFS_VEL0 + 8'(4 * i)) begin
          vel_q[i] <= clamp(merge(vel_q[i], wdata_q, wstrb_q),
                            VEL_MIN, VEL_MAX);
        end
      end
    end
  end

  // Activation, closed loop and error state per axis
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      active_q <= 4'h0;
      error_q <= 4'h0;
      closed_loop_en <= 4'h0;
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (invalid[i]) begin
          // drop sensor, flag error, open the loop
          active_q[i] <= 1'b0;
          error_q[i] <= 1'b1;
          closed_loop_en[i] <= 1'b0;
        end else if (~enable_q[i]) begin
          active_q[i] <= 1'b0;
          closed_loop_en[i] <= 1'b0;
        end else if (~error_q[i] &
                     (activate[i].homing_done |
                      activate[i].powerup_auto)) begin
          // activate after homing or auto power-up
          active_q[i] <= 1'b1;
          closed_loop_en[i] <= 1'b1;
        end else if (wr_fire && waddr_q == OFS_ACTIVE) begin
          active_q[i] <= wdata_q[i];
        end
        // writing zero clears error; a new fault wins
        if (wr_fire && waddr_q == OFS_ERROR && ~wdata_q[i] &&
            ~invalid[i]) begin
          error_q[i] <= 1'b0;
        end
      end
    end
  end

  // any axis error, fault or low amplitude, raises the controller error
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      error_state <= 1'b0;
      zero_request <= 4'h0;
    end else begin
      error_state <= |error_q;
      zero_request <= count_clear;
    end
  end

  // Read address decode
  assign rd_addr = s_axi_araddr;
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok = (rd_addr[1:0] == 2'b00) && (rd_addr < 8'h80);
    unique case (rd_addr)
      OFS_ENABLE: rd_value = {28'h0, enable_q};
      OFS_ACTIVE: rd_value = {28'h0, active_q};
      OFS_DIR: rd_value = {28'h0, dir_q};
      OFS_SIGTYPE: rd_value = {28'h0, sigtype_q};
      OFS_INDEXUSE: rd_value = {28'h0, indexuse_q};
      OFS_FAULTUSE: rd_value = {28'h0, faultuse_q};
      OFS_INDEXLIVE: rd_value = {28'h0, index_live};
      OFS_INDEXLATCH: rd_value = {28'h0, index_latch_q};
      // live fault state, 1 means error
      OFS_FAULTLIVE: rd_value = {28'h0, fault_live};
      OFS_ERROR: rd_value = {28'h0, error_q};
      OFS_CONTROL: rd_value = {24'h0, amp_low_q};
      default: begin
        for (int i = 0; i < AXES; i++) begin
          if (rd_addr == OFS_PERIOD0 + 8'(4 * i)) begin
            rd_value = period_q[i];
          end
          if (rd_addr == OFS_VEL0 + 8'(4 * i)) begin
            rd_value = vel_q[i];
          end
          if (rd_addr == OFS_AMP0 + 8'(4 * i)) begin
            rd_value = {24'h0, amp_q[i]};
          end
          if (rd_addr == OFS_COUNT0 + 8'(4 * i)) begin
            rd_value = count[i];
          end
        end
      end
    endcase
  end

  // Single-cycle read answer after address is taken
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // latch index, clear on read; new mark wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      index_latch_q <= 4'h0;
    end else begin
      if (rd_fire && rd_addr == OFS_INDEXLATCH) begin
        index_latch_q <= index_live;
      end else begin
        index_latch_q <= index_latch_q | index_live;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/sensor_model.sv ***
// Behavioural incremental sensor: quadrature, index mark and fault pins
`timescale 1ns/1ps
`default_nettype none
module sensor_model
  import sensor_frontend_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic step,
  input wire logic idx,
  input wire logic fault,
  output sensor_frontend_pkg::sensor_pins_type pins
);
  logic [1:0] phase_q;
  // One quarter period per step; the bench spaces steps for the synchroniser
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase_q <= 2'h0;
    end else if (step) begin
      phase_q <= phase_q + 2'h1;
    end
  end
  // Gray-coded A/B so exactly one line moves per edge
  // fault is driven as a low level
  assign pins = {phase_q[1], ^phase_q, idx, ~fault};
endmodule
`default_nettype wire

// *** bench/axis_position_sensor_frontend_props.sv ***
// Bus handshake and status timing assertions for the sensor front end
`timescale 1ns/1ps
`default_nettype none
module axis_position_sensor_frontend_props
  import sensor_frontend_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire sensor_frontend_pkg::activate_type activate [4],
  input wire logic [3:0] closed_loop_en,
  input wire logic [3:0] zero_request,
  input wire logic error_state,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic act_seen_q;
  // Sticky record of an activation request on axis 2 since reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      act_seen_q <= 1'b0;
    end else if (activate[2].homing_done | activate[2].powerup_auto) begin
      act_seen_q <= 1'b1;
    end
  end
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held past one cycle");
  AST_W_PULSE: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready held past one cycle");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid not released after bready");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid not released after rready");
  AST_AR_TO_R: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_BAD_READ: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[1:0] != 2'b00 |=> s_axi_rresp == RESP_SLVERR)
    else $error("unaligned read not refused");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready
    |-> ##[1:4] s_axi_bvalid) else $error("write response missing");
  AST_CL_NEEDS_ACT: assert property ($rose(closed_loop_en[2]) |-> act_seen_q)
    else $error("closed loop without activation");
  AST_ZERO_PULSE: assert property (zero_request[1] |=> !zero_request[1])
    else $error("zero request longer than a pulse");
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property ($rose(error_state));
  cover property ($rose(closed_loop_en[2]));
  cover property ($rose(zero_request[1]));
endmodule
bind axis_position_sensor_frontend axis_position_sensor_frontend_props
  axis_position_sensor_frontend_props_i (.core_clk(core_clk), .reset(reset),
  .activate(activate), .closed_loop_en(closed_loop_en),
  .zero_request(zero_request), .error_state(error_state),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// *** bench/axis_position_sensor_frontend_tb_top.sv ***
// Self-checking bench for the four-axis sensor front end
`timescale 1ns/1ps
`default_nettype none
module axis_position_sensor_frontend_tb_top;
  import sensor_frontend_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_type;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  sensor_pins_type pins [4];
  logic [7:0] amp_raw [4];
  activate_type activate [4];
  logic at_lower_limit [4], step [4], idx [4], flt [4];
  logic [3:0] closed_loop_en, zero_request, s_axi_wstrb;
  logic error_state, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // Register rows: reset values first, then writes with their readback
  row_type rows [13] = '{
    '{1'b0, OFS_PERIOD0, 32'h0, PERIOD_RST}, '{1'b0, OFS_VEL0, 32'h0, VEL_RST},
    '{1'b0, OFS_CONTROL, 32'h0, {24'h0, AMP_LOW_RST}},
    '{1'b0, OFS_ENABLE, 32'h0, 32'h0},
    '{1'b1, OFS_ENABLE, 32'hffff_fff5, 32'h5},
    '{1'b1, OFS_PERIOD0 + 8'hc, PERIOD_MIN, PERIOD_MIN},
    '{1'b1, OFS_PERIOD0 + 8'h4, PERIOD_MAX + 32'h1, PERIOD_MAX},
    '{1'b1, OFS_VEL0 + 8'h8, 32'h5, VEL_MIN},
    '{1'b1, OFS_VEL0 + 8'h4, VEL_MAX, VEL_MAX},
    '{1'b1, OFS_SIGTYPE, 32'h3, 32'h3}, '{1'b1, OFS_FAULTUSE, 32'h4, 32'h4},
    '{1'b1, 8'h30, 32'h1, 32'h0}, '{1'b1, OFS_INDEXLIVE, 32'hf, 32'h0}};
  axis_position_sensor_frontend axis_position_sensor_frontend_i (
    .core_clk(core_clk), .reset(reset), .pins(pins), .amp_raw(amp_raw),
    .activate(activate), .at_lower_limit(at_lower_limit),
    .closed_loop_en(closed_loop_en), .zero_request(zero_request),
    .error_state(error_state), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  // One sensor model per axis
  for (genvar g = 0; g < 4; g++) begin : axis
    sensor_model sensor_model_i (.core_clk(core_clk), .reset(reset),
      .step(step[g]), .idx(idx[g]), .fault(flt[g]), .pins(pins[g]));
  end
  always #25 core_clk = ~core_clk;
  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors %0d of %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw | w) begin
      @(posedge core_clk);
      if (s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  // Read and compare; data only judged when an OKAY answer is expected
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
    if (er === RESP_OKAY) chk($sformatf("rdata %h", a), e, s_axi_rdata);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  // One signal period on an axis, edges spaced past the synchroniser
  task automatic period(input int ax);
    repeat (4) begin
      step[ax] <= 1'b1;
      @(posedge core_clk);
      step[ax] <= 1'b0;
      idle(12);
    end
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      amp_raw[i] = 8'h50;
      activate[i] = '0;
      {at_lower_limit[i], step[i], idx[i], flt[i]} = 4'h0;
    end
    amp_raw[0] = 8'hc8;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0_000f;
    s_axi_wdata = 32'h0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (rows[k]) begin
      if (rows[k].wr) wr(rows[k].a, rows[k].d, RESP_OKAY);
      rdc(rows[k].a, rows[k].e, RESP_OKAY);
    end
    rdc(OFS_AMP0, {24'h0, AMP_FULL}, RESP_OKAY);
    rdc(OFS_AMP0 + 8'h8, 32'h50, RESP_OKAY);
    period(1);
    rdc(OFS_COUNT0 + 8'h4, 32'h4, RESP_OKAY);
    wr(OFS_DIR, 32'h2, RESP_OKAY);
    period(1);
    rdc(OFS_COUNT0 + 8'h4, 32'h0, RESP_OKAY);
    // Index mark: live level, then latched flag that clears on read
    idx[0] <= 1'b1;
    idle(10);
    rdc(OFS_INDEXLIVE, 32'h1, RESP_OKAY);
    idx[0] <= 1'b0;
    idle(10);
    rdc(OFS_INDEXLATCH, 32'h1, RESP_OKAY);
    rdc(OFS_INDEXLATCH, 32'h0, RESP_OKAY);
    // Homing done on enabled axis 2 and on disabled axis 3
    activate[2].homing_done <= 1'b1;
    activate[3].homing_done <= 1'b1;
    @(posedge core_clk);
    activate[2].homing_done <= 1'b0;
    activate[3].homing_done <= 1'b0;
    idle(6);
    rdc(OFS_ACTIVE, 32'h4, RESP_OKAY);
    chk("closed_loop_en", 32'h4, {28'h0, closed_loop_en});
    wr(OFS_DIR, 32'h4, RESP_OKAY);
    rdc(OFS_DIR, 32'h0, RESP_OKAY);
    // Sensor fault on axis 2 with fault use set
    flt[2] <= 1'b1;
    idle(10);
    rdc(OFS_FAULTLIVE, 32'h4, RESP_OKAY);
    rdc(OFS_ERROR, 32'h4, RESP_OKAY);
    rdc(OFS_ACTIVE, 32'h0, RESP_OKAY);
    chk("closed_loop_en", 32'h0, {28'h0, closed_loop_en});
    chk("error_state", 32'h1, {31'h0, error_state});
    flt[2] <= 1'b0;
    idle(10);
    wr(OFS_ERROR, 32'h0, RESP_OKAY);
    rdc(OFS_ERROR, 32'h0, RESP_OKAY);
    chk("error_state", 32'h0, {31'h0, error_state});
    // Low amplitude on an analog axis after reactivation
    activate[2].powerup_auto <= 1'b1;
    @(posedge core_clk);
    activate[2].powerup_auto <= 1'b0;
    idle(6);
    chk("closed_loop_en", 32'h4, {28'h0, closed_loop_en});
    amp_raw[2] <= 8'h10;
    idle(6);
    chk("error_state", 32'h1, {31'h0, error_state});
    chk("closed_loop_en", 32'h0, {28'h0, closed_loop_en});
    rdc(8'h02, 32'h0, RESP_SLVERR);
    wr(8'h80, 32'h1, RESP_SLVERR);
    // Index zeroing during homing on axis 1
    wr(OFS_INDEXUSE, 32'h2, RESP_OKAY);
    period(1);
    rdc(OFS_COUNT0 + 8'h4, 32'h4, RESP_OKAY);
    at_lower_limit[1] <= 1'b1;
    idx[1] <= 1'b1;
    for (int t = 0; t < 40 && zero_request[1] !== 1'b1; t++) idle(1);
    chk("zero_request", 32'h1, {31'h0, zero_request[1]});
    idle(4);
    rdc(OFS_COUNT0 + 8'h4, 32'h0, RESP_OKAY);
    at_lower_limit[1] <= 1'b0;
    idx[1] <= 1'b0;
    // Mid-run reset: defaults back, and no false fault while pins settle
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    @(posedge core_clk);
    rdc(OFS_FAULTLIVE, 32'h0, RESP_OKAY);
    rdc(OFS_ENABLE, 32'h0, RESP_OKAY);
    final_report();
  end
endmodule
`default_nettype wire
